// File: instrument_system_state_commands_tb.sv
`timescale 1ns/1ns
module instrument_system_state_commands_tb;
    import isc_pkg::*;
    logic mclk = 0, rst = 1, cmdValid = 0, selfTestFail = 0, errPush = 0;
    logic toLocal = 0, remoteIn, dispOnState, annunEnable, errAnnun;
    logic outEnable, relayA, relayB;
    isc_cmd_t cmdCode = CMD_NOP;
    isc_param_t cmdParam = PRM_CURR;
    logic [31:0] cmdData = 0, seed = 32'h1DC218E9, v, outVoltProg, outCurrProg;
    logic [31:0] voltLevel, mdl [1:5];
    logic [2:0] cmdLoc = 0;
    logic [7:0] errPushCode = 0, errCode, tstResult, q [$];
    logic [4:0] errCount, rdev;
    logic [3:0] textLen, nameLen;
    logic dispEn;
    logic [TXT_LEN-1:0][7:0] textChar, textPunct;
    logic [NAME_MAX-1:0][7:0] nameData;
    wire [19:0] ver;
    wire [47:0] idn;
    int errors = 0, samples_checked = 0, cyc = 0, i;
    always #25 mclk = ~mclk;
    isc_host_model i_host (.mclk(mclk), .rst(rst), .toLocal(toLocal),
        .remoteIn(remoteIn));
    isc_top i_dut (.mclk(mclk), .rst(rst), .remoteIn(remoteIn),
        .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData),
        .cmdLoc(cmdLoc), .cmdParam(cmdParam), .selfTestFail(selfTestFail),
        .errPush(errPush), .errPushCode(errPushCode), .dispEnable(dispEn),
        .annunEnable(annunEnable), .errAnnun(errAnnun),
        .dispOnState(dispOnState), .textChar(textChar),
        .textPunct(textPunct), .textLen(textLen), .outEnable(outEnable),
        .outVoltProg(outVoltProg),
        .outCurrProg(outCurrProg), .relayA(relayA), .relayB(relayB),
        .errCode(errCode), .errCount(errCount), .tstResult(tstResult),
        .versionYear(ver[19:4]), .versionRel(ver[3:0]),
        .idnMaker(idn[47:40]), .idnModel(idn[39:32]), .idnZero(idn[31:24]),
        .idnFwMain(idn[23:16]), .idnFwIo(idn[15:8]), .idnFwPanel(idn[7:0]),
        .rdevAddr(rdev), .nameData(nameData), .nameLenOut(nameLen),
        .currLevel(), .currStep(), .currTrig(),
        .voltLevel(voltLevel), .voltStep(), .voltTrig(), .ovpLevel(),
        .ovpEnable(), .rangeHigh(), .trigDelay(), .trigImm());
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input isc_cmd_t c, input logic [31:0] d = 0,
                       input logic [2:0] l = 0, input isc_param_t p = PRM_VOLT);
        @(posedge mclk);
        cmdValid <= 1'b1;
        cmdCode <= c;
        cmdData <= d;
        cmdLoc <= l;
        cmdParam <= p;
        @(posedge mclk);
        cmdValid <= 1'b0;
        #1;
    endtask
    task automatic nm(input logic [2:0] l, input int n, input logic [7:0] c);
        cmd(CMD_NAME_BEGIN, 0, l);
        for (int k = 0; k < n; k++) cmd(CMD_NAME_CHAR, c + k);
        cmd(CMD_NAME_END);
        cmd(CMD_NAME_QRY, 0, l);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        chk(dispOnState, 1);
        chk(outCurrProg, CURR_OFF);
        chk({relayA, relayB, outEnable}, 0);
        chk(ver, {VER_YEAR, VER_REL});
        for (i = 0; i < 5; i++) chk(ver[4*i+:4] > 4'h9, 0);
        chk(idn[47:16], {MAKER_ID, MODEL_ID, 8'h00, FW_MAIN});
        chk(idn[15:0], {FW_IO, FW_PANEL});
        $display("reset test done");
        v = xs() & 32'h00FF_FFFF;
        cmd(CMD_PARAM, v);
        cmd(CMD_OUTP, 1);
        chk(outEnable, 1);
        chk(outVoltProg, v);
        cmd(CMD_RELAY, 1);
        chk({relayA, relayB}, 3);
        v = xs() & 32'h1F;
        cmd(CMD_ADDR, v);
        chk(rdev, v);
        for (i = 1; i <= 5; i++) begin
            mdl[i] = xs() & 32'h00FF_FFFF;
            cmd(CMD_PARAM, mdl[i]);
            cmd(CMD_SAV, 0, i[2:0]);
        end
        cmd(CMD_SAV, 0, 3'h4);
        cmd(CMD_RST);
        chk({outEnable, relayA}, 0);
        chk(voltLevel, VOLT_OFF);
        chk(outVoltProg, VOLT_OFF);
        for (i = 1; i <= 5; i++) begin
            cmd(CMD_RCL, 0, i[2:0]);
            chk(voltLevel, i == 4 ? mdl[5] : mdl[i]);
            chk({outEnable, relayB}, 3);
        end
        cmd(CMD_SAV, 0, 3'h0);
        cmd(CMD_SAV, 0, 3'h6);
        q = '{ERR_BAD_LOC, ERR_BAD_LOC};
        chk(errCount, 2);
        $display("storage test done");
        for (i = 0; i < 22; i++) begin
            @(posedge mclk);
            errPush <= 1'b1;
            errPushCode <= xs() | 8'h10;
            @(posedge mclk);
            errPush <= 1'b0;
            if (q.size() < 20) q.push_back(errPushCode);
        end
        #1;
        chk(errCount, 20);
        while (q.size() > 0) begin
            cmd(CMD_ERR_READ);
            chk(errCode, q.pop_front());
        end
        chk({errAnnun, errCount}, 0);
        selfTestFail <= 1'b1;
        cmd(CMD_TST);
        chk(tstResult, TST_FAIL);
        chk(errCount, 1);
        selfTestFail <= 1'b0;
        cmd(CMD_TST);
        chk(tstResult, 0);
        $display("error test done");
        nm(3'h2, 2, "A");
        chk({nameLen, nameData[1], nameData[0]}, {4'h2, "BA"});
        nm(3'h2, 10, "a");
        chk({errCount, nameLen, nameData[0]}, {5'h2, 4'h2, "A"});
        nm(3'h2, 1, " ");
        chk({errCount, nameLen}, {5'h3, 4'h2});
        nm(3'h2, 0, "A");
        chk(nameLen, 0);
        cmd(CMD_RCL, 0, 3'h2);
        chk(voltLevel, mdl[2]);
        nm(3'h7, 0, "A");
        chk(errCount, 5);
        $display("name test done");
        cmd(CMD_TEXT_CHAR, "A");
        cmd(CMD_TEXT_CHAR, ",");
        cmd(CMD_TEXT_CHAR, "B");
        chk(textLen, 2);
        chk({textChar[1], textChar[0], textPunct[0]}, "BA,");
        for (i = 0; i < 12; i++) cmd(CMD_TEXT_CHAR, "X");
        chk(textLen, 11);
        chk(textChar[10], "X");
        cmd(CMD_TEXT_CLR);
        chk(textLen, 0);
        chk(|{textChar, textPunct}, 0);
        cmd(CMD_DISP, 0);
        chk({dispOnState, dispEn, annunEnable, errAnnun}, 1);
        toLocal <= 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        chk(dispOnState, 1);
        $display("display test done");
        close_out();
    end
endmodule

// File: isc_host_model.sv
`timescale 1ns/1ns
// Host side: puts the instrument in remote mode before any command traffic.
module isc_host_model (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic toLocal,
    output logic      remoteIn
);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) remoteIn <= 1'b0;
        else remoteIn <= !toLocal;
    end
endmodule

// File: isc_pkg.sv
package isc_pkg;

    localparam int VAL_W      = 32;
    localparam int DLY_W      = 12;
    localparam int TXT_LEN    = 11;
    localparam int NAME_MAX   = 9;
    localparam int LOC_NUM    = 5;
    localparam int ERRQ_DEPTH = 20;

    localparam logic [2:0] LOC_MIN = 3'h1;
    localparam logic [2:0] LOC_MAX = 3'h5;
    localparam logic [3:0] TXT_LEN_C = 4'hB;
    localparam logic [3:0] NAME_MAX_C = 4'h9;
    localparam logic [4:0] ERRQ_LAST = 5'h13;
    localparam logic [4:0] ERRQ_FULL = 5'h14;

    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_DOT   = 8'h2E;
    localparam logic [7:0] CH_SEMI  = 8'h3B;
    localparam logic [7:0] CH_SPACE = 8'h20;

    localparam logic [7:0] ERR_NONE       = 8'h00;
    localparam logic [7:0] ERR_SELFTEST   = 8'h01;
    localparam logic [7:0] ERR_BAD_LOC    = 8'h02;
    localparam logic [7:0] ERR_EMPTY_LOC  = 8'h03;
    localparam logic [7:0] ERR_NAME_LONG  = 8'h04;
    localparam logic [7:0] ERR_NAME_BLANK = 8'h05;
    localparam logic [7:0] TST_PASS       = 8'h00;
    localparam logic [7:0] TST_FAIL       = 8'h01;

    // Values are in microvolts and microamps.
    localparam logic [VAL_W-1:0] VOLT_OFF     = 32'h0000_0000;
    localparam logic [VAL_W-1:0] CURR_OFF     = 32'h0000_4E20;
    localparam logic [VAL_W-1:0] CURR_RST     = 32'h002D_C6C0;
    localparam logic [VAL_W-1:0] CURR_STEP_RST = 32'h0000_0034;
    localparam logic [VAL_W-1:0] VOLT_STEP_RST = 32'h0000_015E;
    localparam logic [VAL_W-1:0] OVP_RST      = 32'h014F_B180;

    // Version and identity fields; the identity values are arbitrary.
    localparam logic [15:0] VER_YEAR  = 16'h1999;
    localparam logic [3:0]  VER_REL   = 4'h0;
    localparam logic [7:0]  MAKER_ID  = 8'hA5;
    localparam logic [7:0]  MODEL_ID  = 8'h5A;
    localparam logic [7:0]  IDN_ZERO  = 8'h00;
    localparam logic [7:0]  FW_MAIN   = 8'h11;
    localparam logic [7:0]  FW_IO     = 8'h22;
    localparam logic [7:0]  FW_PANEL  = 8'h33;

    typedef enum logic [4:0] {
        CMD_NOP        = 5'h00,
        CMD_DISP       = 5'h01,
        CMD_TEXT_CHAR  = 5'h02,
        CMD_TEXT_CLR   = 5'h03,
        CMD_OUTP       = 5'h04,
        CMD_RELAY      = 5'h05,
        CMD_ERR_READ   = 5'h06,
        CMD_TST        = 5'h07,
        CMD_RST        = 5'h08,
        CMD_SAV        = 5'h09,
        CMD_RCL        = 5'h0A,
        CMD_NAME_BEGIN = 5'h0B,
        CMD_NAME_CHAR  = 5'h0C,
        CMD_NAME_END   = 5'h0D,
        CMD_NAME_QRY   = 5'h0E,
        CMD_ADDR       = 5'h0F,
        CMD_PARAM      = 5'h10
    } isc_cmd_t;

    typedef enum logic [3:0] {
        PRM_CURR      = 4'h0,
        PRM_CURR_STEP = 4'h1,
        PRM_CURR_TRIG = 4'h2,
        PRM_VOLT      = 4'h3,
        PRM_VOLT_STEP = 4'h4,
        PRM_VOLT_TRIG = 4'h5,
        PRM_OVP       = 4'h6,
        PRM_OVP_EN    = 4'h7,
        PRM_RANGE     = 4'h8,
        PRM_TRIG_DLY  = 4'h9,
        PRM_TRIG_SRC  = 4'hA
    } isc_param_t;

    typedef struct packed {
        logic [VAL_W-1:0] currLevel;
        logic [VAL_W-1:0] currStep;
        logic [VAL_W-1:0] currTrig;
        logic [VAL_W-1:0] voltLevel;
        logic [VAL_W-1:0] voltStep;
        logic [VAL_W-1:0] voltTrig;
        logic [VAL_W-1:0] ovpLevel;
        logic             ovpEn;
        logic             rangeHigh;
        logic [DLY_W-1:0] trigDelay;
        logic             trigImm;
        logic             outEn;
        logic             relay;
    } isc_set_t;

    localparam isc_set_t SET_RST = '{
        currLevel: CURR_RST, currStep: CURR_STEP_RST, currTrig: CURR_RST,
        voltLevel: VOLT_OFF, voltStep: VOLT_STEP_RST, voltTrig: VOLT_OFF,
        ovpLevel: OVP_RST, ovpEn: 1'b1, default: '0};

    typedef struct packed {
        isc_set_t                                 live;
        logic                                     dispOn;
        logic [TXT_LEN-1:0][7:0]                  textCh;
        logic [TXT_LEN-1:0][7:0]                  textPunct;
        logic [3:0]                               textLen;
        isc_set_t [LOC_NUM-1:0]                   memSet;
        logic [LOC_NUM-1:0]                       memDisp;
        logic [LOC_NUM-1:0]                       memValid;
        logic [LOC_NUM-1:0][NAME_MAX-1:0][7:0]    names;
        logic [LOC_NUM-1:0][3:0]                  nameLen;
        logic [NAME_MAX-1:0][7:0]                 stBuf;
        logic [3:0]                               stLen;
        logic [2:0]                               stIdx;
        logic                                     stOpen;
        logic                                     stLong;
        logic                                     stBlank;
        logic [NAME_MAX-1:0][7:0]                 nameOut;
        logic [3:0]                               nameOutLen;
        logic [ERRQ_DEPTH-1:0][7:0]               errQ;
        logic [4:0]                               errHead;
        logic [4:0]                               errCount;
        logic [7:0]                               errOut;
        logic [7:0]                               tstResult;
        logic [4:0]                               rdevAddr;
        logic                                     remSync1;
        logic                                     remSync2;
        logic                                     remPrev;
    } isc_state_t;

    localparam isc_state_t ST_RST = '{live: SET_RST, dispOn: 1'b1,
                                      default: '0};

endpackage

// File: isc_top.sv
`timescale 1ns/1ns
// Function
// - Display off stops panel updates and all indicators but error; query 0/1.
// - Returning from remote to local forces display on.
// - Message holds 11 positions; comma, period, semicolon share previous one.
// - Stored message readable as text; clear command erases it.
// - Output off programs 0 V and 20 mA; output off after reset.
// - Output state reads 0 when disabled, 1 when enabled.
// - Relay command drives both relay lines together; readable; off after reset.
// - Error queue holds 20 records, read oldest first.
// - Reading out every error empties queue and turns error indicator off.
// - Version reads as year digits plus release digit.
// - Peripheral address write changes only outgoing destination; readable.
// - Identity gives maker, model, constant zero, three firmware revisions.
// - Self-test returns 0 on pass, non-zero on fail plus error record.
// - Reset loads power-on defaults for display, output, relay, trigger, voltage.
// - Five storage locations numbered 1 to 5.
// - Save overwrites silently; reset leaves stored locations alone.
// - Saved state holds all current, voltage, trigger, output and relay settings.
// - Recall restores chosen location; all locations start empty.
// - Display setting saved and recalled only in remote; local forces on.
// - Names at most nine characters, no blanks; longer name raises error.
// - Name query returns name or empty; empty naming erases name only.
module isc_top
    import isc_pkg::*;
(
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic                     remoteIn,
    input  wire logic                     cmdValid,
    input  wire isc_cmd_t                 cmdCode,
    input  wire logic [VAL_W-1:0]         cmdData,
    input  wire logic [2:0]               cmdLoc,
    input  wire isc_param_t               cmdParam,
    input  wire logic                     selfTestFail,
    input  wire logic                     errPush,
    input  wire logic [7:0]               errPushCode,
    output logic                          dispEnable,
    output logic                          annunEnable,
    output logic                          errAnnun,
    output logic                          dispOnState,
    output logic [TXT_LEN-1:0][7:0]       textChar,
    output logic [TXT_LEN-1:0][7:0]       textPunct,
    output logic [3:0]                    textLen,
    output logic                          outEnable,
    output logic [VAL_W-1:0]              outVoltProg,
    output logic [VAL_W-1:0]              outCurrProg,
    output logic                          relayA,
    output logic                          relayB,
    output logic [7:0]                    errCode,
    output logic [4:0]                    errCount,
    output logic [7:0]                    tstResult,
    output logic [15:0]                   versionYear,
    output logic [3:0]                    versionRel,
    output logic [7:0]                    idnMaker,
    output logic [7:0]                    idnModel,
    output logic [7:0]                    idnZero,
    output logic [7:0]                    idnFwMain,
    output logic [7:0]                    idnFwIo,
    output logic [7:0]                    idnFwPanel,
    output logic [4:0]                    rdevAddr,
    output logic [NAME_MAX-1:0][7:0]      nameData,
    output logic [3:0]                    nameLenOut,
    output logic [VAL_W-1:0]              currLevel,
    output logic [VAL_W-1:0]              currStep,
    output logic [VAL_W-1:0]              currTrig,
    output logic [VAL_W-1:0]              voltLevel,
    output logic [VAL_W-1:0]              voltStep,
    output logic [VAL_W-1:0]              voltTrig,
    output logic [VAL_W-1:0]              ovpLevel,
    output logic                          ovpEnable,
    output logic                          rangeHigh,
    output logic [DLY_W-1:0]              trigDelay,
    output logic                          trigImm
);

    isc_state_t s_r;
    isc_state_t s_nxt;
    logic       locOk;
    logic [2:0] locIdx;
    logic       isPunct;
    logic       pushEn;
    logic [7:0] pushCode;
    logic       popEn;
    logic [5:0] tailSum;
    logic [4:0] tail;

    assign locOk = (cmdLoc >= LOC_MIN) && (cmdLoc <= LOC_MAX);
    assign locIdx = cmdLoc - LOC_MIN;
    assign isPunct = (cmdData[7:0] == CH_COMMA) || (cmdData[7:0] == CH_DOT)
                     || (cmdData[7:0] == CH_SEMI);

    always_comb begin
        s_nxt = s_r;
        pushEn = 1'b0;
        pushCode = ERR_NONE;
        popEn = 1'b0;
        tailSum = '0;
        tail = '0;
        s_nxt.remSync1 = remoteIn;
        s_nxt.remSync2 = s_r.remSync1;
        s_nxt.remPrev = s_r.remSync2;
        if (cmdValid) begin
            unique case (cmdCode)
                CMD_DISP: begin
                    s_nxt.dispOn = cmdData[0];
                end
                CMD_TEXT_CHAR: begin
                    if (isPunct && s_r.textLen != 4'h0) begin
                        s_nxt.textPunct[s_r.textLen - 4'h1] = cmdData[7:0];
                    end else if (s_r.textLen < TXT_LEN_C) begin
                        s_nxt.textCh[s_r.textLen] = cmdData[7:0];
                        s_nxt.textLen = s_r.textLen + 4'h1;
                    end
                end
                CMD_TEXT_CLR: begin
                    s_nxt.textCh = '0;
                    s_nxt.textPunct = '0;
                    s_nxt.textLen = 4'h0;
                end
                CMD_OUTP: begin
                    s_nxt.live.outEn = cmdData[0];
                end
                CMD_RELAY: begin
                    s_nxt.live.relay = cmdData[0];
                end
                CMD_ERR_READ: begin
                    popEn = 1'b1;
                end
                CMD_TST: begin
                    if (selfTestFail) begin
                        s_nxt.tstResult = TST_FAIL;
                        pushEn = 1'b1;
                        pushCode = ERR_SELFTEST;
                    end else begin
                        s_nxt.tstResult = TST_PASS;
                    end
                end
                CMD_RST: begin
                    s_nxt.live = SET_RST;
                    s_nxt.dispOn = 1'b1;
                end
                CMD_SAV: begin
                    if (!locOk) begin
                        pushEn = 1'b1;
                        pushCode = ERR_BAD_LOC;
                    end else begin
                        s_nxt.memSet[locIdx] = s_r.live;
                        s_nxt.memValid[locIdx] = 1'b1;
                        if (s_r.remSync2) begin
                            s_nxt.memDisp[locIdx] = s_r.dispOn;
                        end
                    end
                end
                CMD_RCL: begin
                    if (!locOk) begin
                        pushEn = 1'b1;
                        pushCode = ERR_BAD_LOC;
                    end else if (!s_r.memValid[locIdx]) begin
                        pushEn = 1'b1;
                        pushCode = ERR_EMPTY_LOC;
                    end else begin
                        s_nxt.live = s_r.memSet[locIdx];
                        if (s_r.remSync2) begin
                            s_nxt.dispOn = s_r.memDisp[locIdx];
                        end
                    end
                end
                CMD_NAME_BEGIN: begin
                    if (!locOk) begin
                        pushEn = 1'b1;
                        pushCode = ERR_BAD_LOC;
                        s_nxt.stOpen = 1'b0;
                    end else begin
                        s_nxt.stOpen = 1'b1;
                        s_nxt.stIdx = locIdx;
                        s_nxt.stLen = 4'h0;
                        s_nxt.stBuf = '0;
                        s_nxt.stLong = 1'b0;
                        s_nxt.stBlank = 1'b0;
                    end
                end
                CMD_NAME_CHAR: begin
                    if (s_r.stOpen) begin
                        if (cmdData[7:0] == CH_SPACE) begin
                            s_nxt.stBlank = 1'b1;
                        end
                        if (s_r.stLen < NAME_MAX_C) begin
                            s_nxt.stBuf[s_r.stLen] = cmdData[7:0];
                            s_nxt.stLen = s_r.stLen + 4'h1;
                        end else begin
                            s_nxt.stLong = 1'b1;
                        end
                    end
                end
                CMD_NAME_END: begin
                    if (s_r.stOpen) begin
                        s_nxt.stOpen = 1'b0;
                        if (s_r.stLong) begin
                            pushEn = 1'b1;
                            pushCode = ERR_NAME_LONG;
                        end else if (s_r.stBlank) begin
                            pushEn = 1'b1;
                            pushCode = ERR_NAME_BLANK;
                        end else begin
                            s_nxt.names[s_r.stIdx] = s_r.stBuf;
                            s_nxt.nameLen[s_r.stIdx] = s_r.stLen;
                        end
                    end
                end
                CMD_NAME_QRY: begin
                    if (!locOk) begin
                        pushEn = 1'b1;
                        pushCode = ERR_BAD_LOC;
                    end else begin
                        s_nxt.nameOut = s_r.names[locIdx];
                        s_nxt.nameOutLen = s_r.nameLen[locIdx];
                    end
                end
                CMD_ADDR: begin
                    s_nxt.rdevAddr = cmdData[4:0];
                end
                CMD_PARAM: begin
                    unique case (cmdParam)
                        PRM_CURR:      s_nxt.live.currLevel = cmdData;
                        PRM_CURR_STEP: s_nxt.live.currStep = cmdData;
                        PRM_CURR_TRIG: s_nxt.live.currTrig = cmdData;
                        PRM_VOLT:      s_nxt.live.voltLevel = cmdData;
                        PRM_VOLT_STEP: s_nxt.live.voltStep = cmdData;
                        PRM_VOLT_TRIG: s_nxt.live.voltTrig = cmdData;
                        PRM_OVP:       s_nxt.live.ovpLevel = cmdData;
                        PRM_OVP_EN:    s_nxt.live.ovpEn = cmdData[0];
                        PRM_RANGE:     s_nxt.live.rangeHigh = cmdData[0];
                        PRM_TRIG_DLY:  s_nxt.live.trigDelay = cmdData[DLY_W-1:0];
                        PRM_TRIG_SRC:  s_nxt.live.trigImm = cmdData[0];
                        default: begin
                        end
                    endcase
                end
                default: begin
                end
            endcase
        end
        if (s_r.remPrev && !s_r.remSync2) begin
            s_nxt.dispOn = 1'b1;
        end
        if (!pushEn && errPush) begin
            pushEn = 1'b1;
            pushCode = errPushCode;
        end
        if (popEn) begin
            if (s_r.errCount != 5'h0) begin
                s_nxt.errOut = s_r.errQ[s_r.errHead];
                s_nxt.errHead = (s_r.errHead == ERRQ_LAST) ? 5'h0
                                : s_r.errHead + 5'h1;
                s_nxt.errCount = s_r.errCount - 5'h1;
            end else begin
                s_nxt.errOut = ERR_NONE;
            end
        end
        tailSum = {1'b0, s_nxt.errHead} + {1'b0, s_nxt.errCount};
        tail = (tailSum >= {1'b0, ERRQ_FULL}) ? 5'(tailSum - {1'b0, ERRQ_FULL})
               : tailSum[4:0];
        if (pushEn && s_nxt.errCount < ERRQ_FULL) begin
            s_nxt.errQ[tail] = pushCode;
            s_nxt.errCount = s_nxt.errCount + 5'h1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dispEnable = s_r.dispOn;
    assign annunEnable = s_r.dispOn;
    assign errAnnun = (s_r.errCount != 5'h0);
    assign dispOnState = s_r.dispOn;
    assign textChar = s_r.textCh;
    assign textPunct = s_r.textPunct;
    assign textLen = s_r.textLen;
    assign outEnable = s_r.live.outEn;
    assign outVoltProg = s_r.live.outEn ? s_r.live.voltLevel : VOLT_OFF;
    assign outCurrProg = s_r.live.outEn ? s_r.live.currLevel : CURR_OFF;
    assign relayA = s_r.live.relay;
    assign relayB = s_r.live.relay;
    assign errCode = s_r.errOut;
    assign errCount = s_r.errCount;
    assign tstResult = s_r.tstResult;
    assign versionYear = VER_YEAR;
    assign versionRel = VER_REL;
    assign idnMaker = MAKER_ID;
    assign idnModel = MODEL_ID;
    assign idnZero = IDN_ZERO;
    assign idnFwMain = FW_MAIN;
    assign idnFwIo = FW_IO;
    assign idnFwPanel = FW_PANEL;
    assign rdevAddr = s_r.rdevAddr;
    assign nameData = s_r.nameOut;
    assign nameLenOut = s_r.nameOutLen;
    assign currLevel = s_r.live.currLevel;
    assign currStep = s_r.live.currStep;
    assign currTrig = s_r.live.currTrig;
    assign voltLevel = s_r.live.voltLevel;
    assign voltStep = s_r.live.voltStep;
    assign voltTrig = s_r.live.voltTrig;
    assign ovpLevel = s_r.live.ovpLevel;
    assign ovpEnable = s_r.live.ovpEn;
    assign rangeHigh = s_r.live.rangeHigh;
    assign trigDelay = s_r.live.trigDelay;
    assign trigImm = s_r.live.trigImm;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence seq_bad_save;
        cmdValid && (cmdCode == CMD_SAV) && !locOk && errCount < ERRQ_FULL;
    endsequence

    sequence seq_last_read;
        cmdValid && (cmdCode == CMD_ERR_READ) && errCount == 5'h1 && !errPush;
    endsequence

    a_disp_off_annun: assert property (
        !dispOnState |-> !dispEnable && !annunEnable)
        else $error("Indicators active while display is off.");

    a_local_disp_on: assert property (
        $fell(s_r.remSync2) |=> dispOnState)
        else $error("Display not forced on entering local mode.");

    a_text_limit: assert property (
        textLen <= TXT_LEN_C)
        else $error("Message longer than the display allows.");

    a_out_off_prog: assert property (
        !outEnable |-> outVoltProg == VOLT_OFF && outCurrProg == CURR_OFF)
        else $error("Disabled output not at 0 V and 20 mA.");

    a_relay_pair: assert property (
        relayA == relayB)
        else $error("Relay lines disagree.");

    a_errq_last: assert property (
        seq_last_read |=> !errAnnun && errCount == 5'h0)
        else $error("Error indicator still on after last read.");

    a_tst_fail: assert property (
        cmdValid && cmdCode == CMD_TST && selfTestFail
        |=> tstResult != TST_PASS && errCount != 5'h0)
        else $error("Failed self-test not reported.");

    a_rst_defaults: assert property (
        cmdValid && cmdCode == CMD_RST
        |=> !outEnable && !relayA && dispOnState && trigDelay == '0
            && !trigImm && ovpEnable && !rangeHigh)
        else $error("Reset defaults not loaded.");

    a_bad_loc_err: assert property (
        seq_bad_save |=> errCount == $past(errCount) + 5'h1
                         && s_r.memSet == $past(s_r.memSet))
        else $error("Bad location not rejected.");

endmodule
